// [inc/diag_seq_defines.svh]
// timing and field constants for the load diagnostic sequencer
`ifndef DIAG_SEQ_DEFINES_SVH
`define DIAG_SEQ_DEFINES_SVH
`define CLK_HZ 10000000
`define MS_CYC(ms) ((ms) * (`CLK_HZ / 1000))
`define RAMP_MS 10
`define RAIL_MS 10
`define SHORT_PLAT_MS 80
`define LOAD_PLAT_BASE_MS 140
`define LOAD_PLAT_CAP_MS 86
`define LOAD_PLAT_LIM_MS 80
`define RESTART_MS 2
`define PERM_PLAT_MS 80
`define I_SHORT_SPK_MA 8'hC8
`define I_SHORT_LINE_MA 8'h28
`define I_OPEN_SPK_MA 8'h28
`define I_OPEN_LINE_MA 8'h02
`define FB_GND 0
`define FB_VS 1
`define FB_OPEN 2
`define FB_ACROSS 3
`define FB_PLAT_DONE 4
`define FB_HARD_OK 6
`endif

// [inc/diag_seq_pkg.sv]
// types for the load diagnostic sequencer
package diag_seq_pkg;
  typedef enum logic [2:0] {
    T_IDLE = 3'h0, T_SS_RISE = 3'h1, T_SS_PLAT = 3'h3, T_SS_FALL = 3'h2,
    T_RAIL_UP = 3'h6, T_TEST = 3'h7, T_RAIL_DN = 3'h5, T_DONE = 3'h4
  } turnon_state_t;
  typedef enum logic [1:0] {
    P_PLAY = 2'h0, P_RESTART = 2'h1, P_PLATEAU = 2'h3, P_WAIT = 2'h2
  } perm_state_t;
  typedef logic [7:0] fault_byte_t;
endpackage

// [inc/chan_if.sv]
// control and status bundle between the sequencer and one channel
`timescale 1ns/1ns
interface chan_if;
  logic diag_en;
  logic overcur;
  logic fault_gnd;
  logic fault_vs;
  logic fault_across;
  logic clear;
  logic reread;
  logic shut;
  logic [7:0] fault_byte;
  modport ctl (output diag_en, overcur, fault_gnd, fault_vs, fault_across, clear, reread,
    input shut, fault_byte);
  modport chan (input diag_en, overcur, fault_gnd, fault_vs, fault_across, clear, reread,
    output shut, fault_byte);
endinterface

// [design/perm_chan.sv]
// per-channel permanent diagnostic state machine
`timescale 1ns/1ns
`include "diag_seq_defines.svh"
module perm_chan #(
  parameter int RESTART_CYC = `MS_CYC(`RESTART_MS),
  parameter int PLAT_CYC = `MS_CYC(`PERM_PLAT_MS)
) (
  input wire logic clk,
  input wire logic rst_n,
  chan_if.chan c
);
  import diag_seq_pkg::*;
  perm_state_t st_q, st_d;
  logic [23:0] cnt_q, cnt_d;
  logic [7:0] fb_q, fb_d;
  logic restart_end, plat_end;
  assign restart_end = (cnt_q == 24'(RESTART_CYC - 1));
  assign plat_end = (cnt_q == 24'(PLAT_CYC - 1));
  assign c.shut = (st_q != P_PLAY);
  assign c.fault_byte = fb_q;
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 24'h1;
    fb_d = fb_q;
    case (st_q)
      P_PLAY: begin
        cnt_d = 24'h0;
        if (c.overcur) begin
          st_d = P_RESTART;
        end
      end
      P_RESTART: begin
        // only the level at the end of the pulse counts, so a spike at its start is filtered out
        if (restart_end) begin
          cnt_d = 24'h0;
          if (!c.overcur) begin
            st_d = P_PLAY;
          end else if (c.diag_en && !fb_q[`FB_PLAT_DONE]) begin
            st_d = P_PLATEAU;
          end
        end
      end
      P_PLATEAU: begin
        if (plat_end) begin
          cnt_d = 24'h0;
          st_d = P_RESTART;
          fb_d[`FB_GND] = c.fault_gnd;
          fb_d[`FB_VS] = c.fault_vs;
          fb_d[`FB_ACROSS] = c.fault_across;
          fb_d[`FB_PLAT_DONE] = 1'b1;
        end
      end
      default: st_d = P_PLAY;
    endcase
    // a read while restarts run re-arms the plateau only if the fault still stands
    if (c.reread && st_q == P_RESTART && c.overcur && c.diag_en) begin
      fb_d[`FB_PLAT_DONE] = 1'b0;
    end
    if (c.clear) begin
      fb_d = 8'h00;
    end
    if (!c.diag_en) begin
      fb_d = 8'h00;
    end
    if (st_q == P_PLATEAU && plat_end) begin
      fb_d[`FB_PLAT_DONE] = c.diag_en;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= P_PLAY;
      cnt_q <= 24'h0;
      fb_q <= 8'h00;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      fb_q <= fb_d;
    end
  end
  a_restart_len: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == P_RESTART && cnt_q == 24'h0) |-> (st_q == P_RESTART) [*8])
    else $error("restart cycle too short");
  a_plat_done_set: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == P_PLATEAU && plat_end && c.diag_en && !c.clear) |=> fb_q[`FB_PLAT_DONE])
    else $error("plateau done bit not set");
  a_restart_off: assert property (@(posedge clk) disable iff (!rst_n)
    !c.diag_en |=> fb_q == 8'h00)
    else $error("fault byte kept in restart mode");
  a_no_plat_off: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == P_RESTART && !c.diag_en) |=> st_q != P_PLATEAU)
    else $error("plateau in restart mode");
  a_restart_first: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == P_PLAY && c.overcur) |=> st_q == P_RESTART)
    else $error("overload did not start restart");
endmodule // perm_chan

// [design/amp_load_diagnostic_sequencer.sv]
// turn-on and permanent load diagnostic sequencer for four channels
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`include "diag_seq_defines.svh"
module amp_load_diagnostic_sequencer #(
  parameter int RAMP_CYC = `MS_CYC(`RAMP_MS),
  parameter int RAIL_CYC = `MS_CYC(`RAIL_MS),
  parameter int SHORT_PLAT_CYC = `MS_CYC(`SHORT_PLAT_MS),
  parameter int RESTART_CYC = `MS_CYC(`RESTART_MS),
  parameter int PERM_PLAT_CYC = `MS_CYC(`PERM_PLAT_MS),
  parameter int MS_CYC_1 = `MS_CYC(1)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic diag_enable_bit,
  input wire logic amp_mode_bit,
  input wire logic biased,
  input wire logic [2:0] plateau_multiplier_field,
  input wire logic [1:0] line_driver_select_bits,
  input wire logic [7:0] pulse_ramp_time,
  input wire logic soft_short_seen,
  input wire logic [3:0] overcurrent,
  input wire logic [3:0] short_gnd_seen,
  input wire logic [3:0] short_vs_seen,
  input wire logic [3:0] short_across_seen,
  input wire logic [3:0] open_load_seen,
  input wire logic [3:0] byte_read,
  output logic [7:0] channel_fault_bytes [4],
  output logic diag_valid_bit,
  output logic [3:0] channel_shut,
  output logic analog_regulator_rail,
  output logic output_raised,
  output logic test_pulse,
  output logic [7:0] short_test_current [4],
  output logic [7:0] open_test_current [4]
);
  import diag_seq_pkg::*;
  //////////////////////////////////////////////////////////////////////
  turnon_state_t st_q, st_d;
  logic [27:0] cnt_q;
  logic en_q;
  logic valid_q;
  logic [1:0] pulse_q;
  logic start, step_end, clear_all;
  logic [3:0] mult;
  logic [27:0] ramp_up, plat_load, phase_len;
  logic [7:0] ru_ms;
  assign start = diag_enable_bit && !en_q && !amp_mode_bit && st_q == T_IDLE;
  assign clear_all = byte_read[3];
  function automatic logic [3:0] mult_of(input logic [2:0] f);
    case (f[1:0])
      2'h0: mult_of = 4'h1;
      2'h1: mult_of = 4'h2;
      2'h2: mult_of = 4'h4;
      default: mult_of = 4'h8;
    endcase
  endfunction
  assign mult = mult_of(plateau_multiplier_field);
  assign ru_ms = pulse_ramp_time;
  // the rail adds its own time to both ramps when it moves
  assign ramp_up = 28'(RAMP_CYC);
  assign plat_load = (28'(`LOAD_PLAT_BASE_MS) > 28'(2 * ru_ms) + 28'(`LOAD_PLAT_LIM_MS)) ?
    28'(`LOAD_PLAT_CAP_MS * MS_CYC_1) * 28'(mult) :
    (28'(`LOAD_PLAT_BASE_MS) - 28'(2 * ru_ms)) * 28'(MS_CYC_1) * 28'(mult);
  always_comb begin
    case (st_q)
      T_SS_RISE, T_SS_FALL: phase_len = ramp_up;
      T_SS_PLAT: phase_len = 28'(SHORT_PLAT_CYC);
      T_RAIL_UP, T_RAIL_DN: phase_len = 28'(RAIL_CYC) + ramp_up;
      T_TEST: phase_len = soft_short_seen ? 28'(SHORT_PLAT_CYC) :
        28'(2 * ru_ms) * 28'(MS_CYC_1) * 28'(mult) + plat_load;
      default: phase_len = 28'h1;
    endcase
  end
  assign step_end = (cnt_q >= phase_len - 28'h1);
  always_comb begin
    st_d = st_q;
    case (st_q)
      T_IDLE: if (start) st_d = T_SS_RISE;
      T_SS_RISE: if (step_end) st_d = T_SS_PLAT;
      T_SS_PLAT: if (step_end) st_d = T_SS_FALL;
      T_SS_FALL: if (step_end) st_d = T_RAIL_UP;
      T_RAIL_UP: if (step_end) st_d = T_TEST;
      T_TEST: if (step_end && (soft_short_seen || pulse_q == 2'h1)) st_d = T_RAIL_DN;
      T_RAIL_DN: if (step_end) st_d = T_DONE;
      T_DONE: st_d = T_IDLE;
      default: st_d = T_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= T_IDLE;
      cnt_q <= 28'h0;
      en_q <= 1'b0;
      pulse_q <= 2'h0;
    end else begin
      st_q <= st_d;
      en_q <= diag_enable_bit;
      cnt_q <= (st_d != st_q || (st_q == T_TEST && step_end)) ? 28'h0 : cnt_q + 28'h1;
      pulse_q <= (st_q == T_TEST && step_end) ? pulse_q + 2'h1 : (st_q == T_IDLE ? 2'h0 : pulse_q);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
    end else if (st_q == T_DONE) begin
      valid_q <= 1'b1;
    end else if (start || clear_all) begin
      valid_q <= 1'b0;
    end
  end
  assign diag_valid_bit = valid_q;
  assign analog_regulator_rail = (st_q == T_RAIL_UP || st_q == T_TEST || st_q == T_RAIL_DN);
  assign output_raised = (st_q != T_IDLE && st_q != T_DONE);
  assign test_pulse = (st_q == T_TEST) && !soft_short_seen;
  //////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : ch
      chan_if cif ();
      logic line_sel;
      logic [7:0] ton_q;
      assign line_sel = (g % 2 == 0) ? line_driver_select_bits[1] : line_driver_select_bits[0];
      assign short_test_current[g] = line_sel ? `I_SHORT_LINE_MA : `I_SHORT_SPK_MA;
      assign open_test_current[g] = line_sel ? `I_OPEN_LINE_MA : `I_OPEN_SPK_MA;
      assign cif.diag_en = diag_enable_bit && biased;
      assign cif.overcur = overcurrent[g] && amp_mode_bit;
      assign cif.fault_gnd = short_gnd_seen[g];
      assign cif.fault_vs = short_vs_seen[g];
      assign cif.fault_across = short_across_seen[g];
      assign cif.clear = clear_all;
      assign cif.reread = byte_read[g];
      assign channel_shut[g] = cif.shut;
      perm_chan #(.RESTART_CYC(RESTART_CYC), .PLAT_CYC(PERM_PLAT_CYC)) u_perm (
        .clk(clk),
        .rst_n(rst_n),
        .c(cif)
      );
      always_ff @(posedge clk) begin
        if (!rst_n || clear_all) begin
          ton_q <= 8'h00;
        end else if (st_q == T_TEST && step_end) begin
          ton_q[`FB_GND] <= short_gnd_seen[g];
          ton_q[`FB_VS] <= short_vs_seen[g];
          ton_q[`FB_ACROSS] <= short_across_seen[g];
          ton_q[`FB_OPEN] <= open_load_seen[g];
          ton_q[`FB_HARD_OK] <= soft_short_seen && !short_gnd_seen[g] && !short_vs_seen[g];
        end
      end
      // turn-on results stay until the permanent machine writes its own
      assign channel_fault_bytes[g] = cif.fault_byte[`FB_PLAT_DONE] ? cif.fault_byte : ton_q;
    end
  endgenerate
  a_tur_start: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == T_IDLE && $rose(diag_enable_bit) && !amp_mode_bit) |=> st_q == T_SS_RISE)
    else $error("turn-on diagnostic did not start");
  a_no_start_play: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == T_IDLE && amp_mode_bit) |=> st_q == T_IDLE)
    else $error("turn-on started in play");
  a_ss_plat_len: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == T_SS_PLAT && st_d != T_SS_PLAT) |-> cnt_q == 28'(SHORT_PLAT_CYC - 1))
    else $error("short plateau scaled");
  a_rail_off_ss: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == T_SS_RISE || st_q == T_SS_PLAT) |-> !analog_regulator_rail)
    else $error("rail on during soft short");
  a_valid_done: assert property (@(posedge clk) disable iff (!rst_n)
    (st_q == T_DONE) |=> diag_valid_bit)
    else $error("valid bit not set");
  a_clear_read: assert property (@(posedge clk) disable iff (!rst_n)
    byte_read[3] |=> (ch[0].ton_q == 8'h00 && ch[3].ton_q == 8'h00))
    else $error("read did not clear bytes");
  a_mult_val: assert property (@(posedge clk) disable iff (!rst_n)
    (mult == 4'h1 || mult == 4'h2 || mult == 4'h4 || mult == 4'h8))
    else $error("bad multiplier");
  a_current_sel: assert property (@(posedge clk) disable iff (!rst_n)
    !line_driver_select_bits[1] |-> short_test_current[0] == `I_SHORT_SPK_MA)
    else $error("wrong test current");
endmodule // amp_load_diagnostic_sequencer

// [sim/load_model.sv]
// behavioural model of the four loudspeaker loads seen by the sequencer
`timescale 1ns/1ns
module load_model (
  input wire logic amp_mode_bit,
  input wire logic output_raised,
  input wire logic test_pulse,
  input wire logic [3:0] gnd_cfg,
  input wire logic [3:0] vs_cfg,
  input wire logic [3:0] across_cfg,
  input wire logic [3:0] open_cfg,
  input wire logic soft_cfg,
  output logic soft_short_seen,
  output logic [3:0] overcurrent,
  output logic [3:0] short_gnd_seen,
  output logic [3:0] short_vs_seen,
  output logic [3:0] short_across_seen,
  output logic [3:0] open_load_seen
);
  //////////////////////////////////////////////////////////////////////
  // only hard shorts draw overload current, and only while the stage plays
  assign overcurrent = (gnd_cfg | vs_cfg | across_cfg) & {4{amp_mode_bit}};
  assign short_gnd_seen = gnd_cfg;
  assign short_vs_seen = vs_cfg;
  assign short_across_seen = across_cfg;
  // comparators only see a leak once the outputs have been lifted
  assign soft_short_seen = soft_cfg & output_raised;
  assign open_load_seen = open_cfg & {4{test_pulse}};
endmodule // load_model

// [sim/amp_load_diagnostic_sequencer_tb.sv]
// self-checking bench for the load diagnostic sequencer
`timescale 1ns/1ns
module amp_load_diagnostic_sequencer_tb;
  // short counts keep the run brief; expectations use the same values
  localparam int RC = 20;
  localparam int RL = 20;
  localparam int SP = 80;
  localparam int RS = 20;
  localparam int PP = 80;
  localparam int M1 = 2;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic diag_enable_bit = 1'b0;
  logic amp_mode_bit = 1'b0;
  logic biased = 1'b1;
  logic [2:0] plateau_multiplier_field = 3'h0;
  logic [1:0] line_driver_select_bits = 2'h0;
  logic [7:0] pulse_ramp_time = 8'h1E;
  logic [3:0] byte_read = 4'h0;
  logic [3:0] gnd_cfg = 4'h0;
  logic [3:0] vs_cfg = 4'h0;
  logic [3:0] across_cfg = 4'h0;
  logic [3:0] open_cfg = 4'h0;
  logic soft_cfg = 1'b0;
  logic soft_short_seen;
  logic [3:0] overcurrent, short_gnd_seen, short_vs_seen, short_across_seen, open_load_seen;
  logic [7:0] channel_fault_bytes [4];
  logic diag_valid_bit;
  logic [3:0] channel_shut;
  logic analog_regulator_rail, output_raised, test_pulse;
  logic [7:0] short_test_current [4];
  logic [7:0] open_test_current [4];
  int mismatches = 0;
  int n_tests = 0;
  int t1, t2, t4, t8, t20, n;
  always #50 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  amp_load_diagnostic_sequencer #(.RAMP_CYC(RC), .RAIL_CYC(RL), .SHORT_PLAT_CYC(SP), .RESTART_CYC(RS),
    .PERM_PLAT_CYC(PP), .MS_CYC_1(M1)) amp_load_diagnostic_sequencer_i (.clk(clk), .rst_n(rst_n),
    .diag_enable_bit(diag_enable_bit), .amp_mode_bit(amp_mode_bit), .biased(biased),
    .plateau_multiplier_field(plateau_multiplier_field), .line_driver_select_bits(line_driver_select_bits),
    .pulse_ramp_time(pulse_ramp_time), .soft_short_seen(soft_short_seen), .overcurrent(overcurrent),
    .short_gnd_seen(short_gnd_seen), .short_vs_seen(short_vs_seen), .short_across_seen(short_across_seen),
    .open_load_seen(open_load_seen), .byte_read(byte_read), .channel_fault_bytes(channel_fault_bytes),
    .diag_valid_bit(diag_valid_bit), .channel_shut(channel_shut), .analog_regulator_rail(analog_regulator_rail),
    .output_raised(output_raised), .test_pulse(test_pulse), .short_test_current(short_test_current),
    .open_test_current(open_test_current));
  load_model load_model_i (.amp_mode_bit(amp_mode_bit), .output_raised(output_raised), .test_pulse(test_pulse),
    .gnd_cfg(gnd_cfg), .vs_cfg(vs_cfg), .across_cfg(across_cfg), .open_cfg(open_cfg), .soft_cfg(soft_cfg),
    .soft_short_seen(soft_short_seen), .overcurrent(overcurrent), .short_gnd_seen(short_gnd_seen),
    .short_vs_seen(short_vs_seen), .short_across_seen(short_across_seen), .open_load_seen(open_load_seen));
  //////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic bit cond(input int w);
    case (w)
      0: return diag_valid_bit === 1'b1;
      1: return diag_valid_bit === 1'b0;
      2: return analog_regulator_rail === 1'b1;
      3: return channel_shut === 4'h0;
      4: return channel_fault_bytes[1][4] === 1'b1;
      default: return channel_fault_bytes[2][4] === 1'b1;
    endcase
  endfunction
  // every wait is bounded; running out ends the run as a failure
  task automatic wait_c(input int w, input int bound, output int cnt);
    cnt = 0;
    while (!cond(w)) begin
      if (cnt >= bound) begin
        mismatches++;
        finish_test();
      end
      @(negedge clk);
      cnt++;
    end
  endtask
  // host read of one fault byte: value checked, then a one-cycle read strobe
  task automatic rd(input int b, input logic [7:0] exp);
    check(channel_fault_bytes[b], exp);
    byte_read[b] = 1'b1;
    @(negedge clk);
    byte_read = 4'h0;
    @(negedge clk);
  endtask
  // one turn-on run with the load faults left as set, timed from the enable edge to valid
  task automatic run_on(input logic [7:0] ramp, input logic [2:0] fld, output int t);
    int a;
    int b;
    diag_enable_bit = 1'b0;
    pulse_ramp_time = ramp;
    plateau_multiplier_field = fld;
    @(negedge clk);
    diag_enable_bit = 1'b1;
    wait_c(1, 50, a);
    wait_c(0, 40000, b);
    t = a + b;
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check(diag_valid_bit, 1'b0);
    check(channel_shut, 4'h0);
    for (int s = 0; s < 4; s++) begin
      line_driver_select_bits = s[1:0];
      @(negedge clk);
      for (int c = 0; c < 4; c++) begin
        check(short_test_current[c], ((c % 2 == 0) ? s[1] : s[0]) ? 8'h28 : 8'hC8);
        check(open_test_current[c], ((c % 2 == 0) ? s[1] : s[0]) ? 8'h02 : 8'h28);
      end
    end
    line_driver_select_bits = 2'h0;
    soft_cfg = 1'b1;
    diag_enable_bit = 1'b1;
    repeat (RC + SP / 2) @(negedge clk);
    check({output_raised, analog_regulator_rail}, 2'b10);
    wait_c(2, 2 * RC + SP, n);
    check(n > RC + SP / 2 - 4 && n < RC + SP / 2 + 4, 1'b1);
    wait_c(0, 4000, n);
    check(analog_regulator_rail, 1'b0);
    check(channel_fault_bytes[0], 8'h40);
    soft_cfg = 1'b0;
    // 30 ms ramp sits on the plateau boundary, 20 ms ramp takes the capped branch
    run_on(8'h1E, 3'h0, t1);
    run_on(8'h14, 3'h0, t20);
    run_on(8'h1E, 3'h1, t2);
    run_on(8'h1E, 3'h2, t4);
    run_on(8'h1E, 3'h3, t8);
    check(t1 - t20, 2 * 14 * M1);
    check(t4 - t2, 2 * (t2 - t1));
    check(t8 - t4, 2 * (t4 - t2));
    open_cfg = 4'h8;
    run_on(8'h1E, 3'h0, n);
    check(n, t1);
    check(channel_fault_bytes[3], 8'h04);
    open_cfg = 4'h0;
    byte_read = 4'h8;
    @(negedge clk);
    byte_read = 4'h0;
    @(negedge clk);
    for (int i = 0; i < 4; i++) check(channel_fault_bytes[i], 8'h00);
    diag_enable_bit = 1'b0;
    amp_mode_bit = 1'b1;
    gnd_cfg = 4'h1;
    repeat (2) @(negedge clk);
    check(channel_shut, 4'h1);
    repeat (3 * RS) @(negedge clk);
    check(channel_shut, 4'h1);
    check(channel_fault_bytes[0], 8'h00);
    gnd_cfg = 4'h0;
    wait_c(3, RS + 4, n);
    diag_enable_bit = 1'b1;
    repeat (5) @(negedge clk);
    check(output_raised, 1'b0);
    across_cfg = 4'h4;
    repeat (3) @(negedge clk);
    check(channel_shut, 4'h4);
    across_cfg = 4'h0;
    wait_c(3, RS + 4, n);
    repeat (PP + RS) @(negedge clk);
    check(channel_fault_bytes[2], 8'h00);
    vs_cfg = 4'h2;
    repeat (RS + PP - 4) @(negedge clk);
    check(channel_fault_bytes[1][4], 1'b0);
    wait_c(4, 12, n);
    check(channel_fault_bytes[1], 8'h12);
    check(channel_shut, 4'h2);
    rd(0, 8'h00);
    rd(1, 8'h12);
    rd(2, 8'h00);
    rd(3, 8'h00);
    check(channel_fault_bytes[1], 8'h00);
    wait_c(4, 2 * RS + PP + 10, n);
    vs_cfg = 4'h0;
    wait_c(3, 2 * RS + 4, n);
    for (int i = 0; i < 4; i++) rd(i, (i == 1) ? 8'h12 : 8'h00);
    repeat (PP + 2 * RS) @(negedge clk);
    check(channel_fault_bytes[1], 8'h00);
    gnd_cfg = 4'h4;
    wait_c(5, 2 * RS + PP + 10, n);
    check(channel_fault_bytes[2], 8'h11);
    diag_enable_bit = 1'b0;
    repeat (3) @(negedge clk);
    check(channel_fault_bytes[2], 8'h00);
    gnd_cfg = 4'h0;
    wait_c(3, 2 * RS + 4, n);
    finish_test();
  end
endmodule // amp_load_diagnostic_sequencer_tb
